/* File: logic/omc_top.v */
/*
  Operating mode controller: mode machine, clock select and gating, wake-up,
  APB slave. Assumes interrupt latches from the interrupt controller and
  glitch-free gating cells behind the clock enables.
*/
`timescale 1ns/10ps
`include "omc_defines.vh"

module omc_top (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         psel,
  input  wire         penable,
  input  wire         pwrite,
  input  wire [11:0]  paddr,
  input  wire [31:0]  pwdata,
  output reg  [31:0]  prdata,
  output wire         pready,
  output wire         pslverr,
  input  wire [7:0]   irq_latch,
  input  wire [7:0]   interrupt_enable_register,
  input  wire         tb_source_clk,
  input  wire         stop_release,
  input  wire         periph_sel_low,
  output reg          main_clk_sel_low_r,
  output reg          cpu_clk_en_r,
  output reg          wdt_clk_en_r,
  output reg          periph_clk_en_r,
  output reg          periph_clk_low_r,
  output reg          tbt_clk_en_r,
  output reg          prescaler_en_r,
  output reg          fast_osc_on_r,
  output reg          low_osc_on_r,
  output reg          low_osc_pins_port_r,
  output reg          time_base_interrupt_r,
  output reg          warmup_done_interrupt_r,
  output reg          service_irq_r
);

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  reg  [7:0]          system_control_one_r;
  reg  [7:0]          system_control_two_r;
  reg  [2:0]          int_ctl_r;
  reg  [7:0]          warmup_compare_value_r;
  reg  [3:0]          mode_r;
  reg  [3:0]          mode_nxt;
  reg  [3:0]          resume_r;
  reg                 tbt_armed_r;
  reg                 tb_meta_r;
  reg                 tb_sync_r;
  reg                 tb_prev_r;
  reg                 rel_meta_r;
  reg                 rel_sync_r;
  reg                 prev_fast_r;
  reg                 prev_low_r;
  wire                tb_fall;
  wire                irq_wake;
  wire                wu_busy;
  wire                wu_done;
  wire                wu_start;
  wire                stop_start;
  wire                sw_start;
  wire                halt_req;
  wire                deep_req;
  wire                stop_req;
  wire                fast_en;
  wire                low_en;
  wire                sel_slow;
  reg                 sw_warm_r;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign halt_req = system_control_two_r[`OMC_C2_HALT];
  assign deep_req = system_control_two_r[`OMC_C2_TIMING_GEN_HALT_BIT];
  assign stop_req = system_control_one_r[`OMC_C1_STOP];
  assign fast_en  = system_control_two_r[`OMC_C2_XEN];
  assign low_en   = system_control_two_r[`OMC_C2_XTEN];
  assign sel_slow = system_control_two_r[`OMC_C2_SYSTEM_CLOCK_SELECT_BIT];
  // Any enabled interrupt latch wakes a CPU halt
  assign irq_wake = |(irq_latch & interrupt_enable_register);
  // ----------------------------------------------------------------
  // Synchronisers for outside levels
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tb_meta_r  <= 1'b0;
      tb_sync_r  <= 1'b0;
      tb_prev_r  <= 1'b0;
      rel_meta_r <= 1'b0;
      rel_sync_r <= 1'b0;
    end
    else
    begin
      tb_meta_r  <= tb_source_clk;
      tb_sync_r  <= tb_meta_r;
      tb_prev_r  <= tb_sync_r;
      rel_meta_r <= stop_release;
      rel_sync_r <= rel_meta_r;
    end
  end
  assign tb_fall = tb_prev_r & ~tb_sync_r;
  // ----------------------------------------------------------------
  // Warm-up counter
  // ----------------------------------------------------------------
  assign stop_start = (mode_r == `OMC_M_STOP) & rel_sync_r;
  assign sw_start   = (fast_en & ~prev_fast_r) | (low_en & ~prev_low_r);
  assign wu_start   = stop_start | (sw_start & (mode_r != `OMC_M_STOP));
  omc_warmup u_warmup (
    .pclk    (pclk),
    .presetn (presetn),
    .start   (wu_start),
    .clear   (1'b0),
    .cmp     (warmup_compare_value_r),
    .busy_r  (wu_busy),
    .done_r  (wu_done)
  );
  // ----------------------------------------------------------------
  // Mode state machine
  // ----------------------------------------------------------------
  always @*
  begin
    mode_nxt = mode_r;
    case (mode_r)
      `OMC_M_SRUN:
        if (stop_req)
          mode_nxt = `OMC_M_STOP;
        else if (deep_req)
          mode_nxt = `OMC_M_SDEEP;
        else if (halt_req)
          mode_nxt = `OMC_M_SHALT;
        else if (low_en)
          mode_nxt = `OMC_M_DFAST;
      `OMC_M_SHALT:
        if (irq_wake)
          mode_nxt = `OMC_M_SRUN;
      `OMC_M_SDEEP:
        if (tb_fall)
          mode_nxt = `OMC_M_SRUN;
      `OMC_M_DFAST:
        if (stop_req)
          mode_nxt = `OMC_M_STOP;
        else if (halt_req)
          mode_nxt = `OMC_M_DHALT;
        else if (sel_slow)
          mode_nxt = `OMC_M_SLOW_RUN_WITH_FAST_OSC;
        else if (!low_en)
          mode_nxt = `OMC_M_SRUN;
      `OMC_M_DHALT:
        if (irq_wake)
          mode_nxt = `OMC_M_DFAST;
      `OMC_M_SLOW_RUN_WITH_FAST_OSC:
        if (stop_req)
          mode_nxt = `OMC_M_STOP;
        else if (!fast_en)
          mode_nxt = `OMC_M_SLOW_RUN_NO_FAST_OSC;
        else if (!sel_slow)
          mode_nxt = `OMC_M_DFAST;
      `OMC_M_SLOW_RUN_NO_FAST_OSC:
        if (stop_req)
          mode_nxt = `OMC_M_STOP;
        else if (deep_req)
          mode_nxt = `OMC_M_SLP0;
        else if (halt_req)
          mode_nxt = `OMC_M_SLP1;
        else if (fast_en && !wu_busy && !wu_start)
          mode_nxt = `OMC_M_SLOW_RUN_WITH_FAST_OSC;
      `OMC_M_SLP1:
        if (irq_wake)
          mode_nxt = `OMC_M_SLOW_RUN_NO_FAST_OSC;
      `OMC_M_SLP0:
        if (tb_fall)
          mode_nxt = `OMC_M_SLOW_RUN_NO_FAST_OSC;
      `OMC_M_STOP:
        if (rel_sync_r)
          mode_nxt = `OMC_M_WARM;
      `OMC_M_WARM:
        if (wu_done)
          mode_nxt = resume_r;
      default:
        mode_nxt = `OMC_M_SRUN;
    endcase
  end
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mode_r      <= `OMC_M_SRUN;
      resume_r    <= `OMC_M_SRUN;
      tbt_armed_r <= 1'b0;
      prev_fast_r <= 1'b1;
      prev_low_r  <= 1'b0;
      sw_warm_r   <= 1'b0;
    end
    else
    begin
      mode_r      <= mode_nxt;
      prev_fast_r <= fast_en;
      prev_low_r  <= low_en;
      if (mode_nxt == `OMC_M_STOP && mode_r != `OMC_M_STOP)
        resume_r <= mode_r;
      // Latch time-base enable at deep-halt entry
      if ((mode_nxt == `OMC_M_SDEEP || mode_nxt == `OMC_M_SLP0) &&
          mode_r != mode_nxt)
        tbt_armed_r <= int_ctl_r[`OMC_IC_TIME_BASE_ENABLE_BIT_CTL];
      if (wu_start && !stop_start)
        sw_warm_r <= 1'b1;
      else if (wu_done)
        sw_warm_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Clock selection and gating
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      main_clk_sel_low_r      <= 1'b0;
      cpu_clk_en_r            <= 1'b1;
      wdt_clk_en_r            <= 1'b1;
      periph_clk_en_r         <= 1'b1;
      periph_clk_low_r        <= 1'b0;
      tbt_clk_en_r            <= 1'b1;
      prescaler_en_r          <= 1'b1;
      fast_osc_on_r           <= 1'b1;
      low_osc_on_r            <= 1'b0;
      low_osc_pins_port_r     <= 1'b1;
      time_base_interrupt_r   <= 1'b0;
      warmup_done_interrupt_r <= 1'b0;
      service_irq_r           <= 1'b0;
    end
    else
    begin
      // Single-clock uses gear only; slow and sleep use quarter low
      main_clk_sel_low_r <= (mode_nxt == `OMC_M_SLOW_RUN_WITH_FAST_OSC) |
                            (mode_nxt == `OMC_M_SLOW_RUN_NO_FAST_OSC) |
                            (mode_nxt == `OMC_M_SLP1)  |
                            (mode_nxt == `OMC_M_SLP0);
      cpu_clk_en_r  <= (mode_nxt == `OMC_M_SRUN)  |
                       (mode_nxt == `OMC_M_DFAST) |
                       (mode_nxt == `OMC_M_SLOW_RUN_WITH_FAST_OSC) |
                       (mode_nxt == `OMC_M_SLOW_RUN_NO_FAST_OSC);
      wdt_clk_en_r  <= (mode_nxt == `OMC_M_SRUN)  |
                       (mode_nxt == `OMC_M_DFAST) |
                       (mode_nxt == `OMC_M_SLOW_RUN_WITH_FAST_OSC) |
                       (mode_nxt == `OMC_M_SLOW_RUN_NO_FAST_OSC);
      periph_clk_en_r <= (mode_nxt != `OMC_M_SDEEP) &
                         (mode_nxt != `OMC_M_SLP0) &
                         (mode_nxt != `OMC_M_STOP) &
                         (mode_nxt != `OMC_M_WARM);
      // Fast run lets peripherals pick; slow modes force quarter low
      periph_clk_low_r <= ((mode_nxt == `OMC_M_DFAST ||
                            mode_nxt == `OMC_M_DHALT) & periph_sel_low) |
                          (mode_nxt == `OMC_M_SLOW_RUN_WITH_FAST_OSC) |
                          (mode_nxt == `OMC_M_SLOW_RUN_NO_FAST_OSC) |
                          (mode_nxt == `OMC_M_SLP1);
      tbt_clk_en_r   <= (mode_nxt != `OMC_M_STOP) &
                        (mode_nxt != `OMC_M_WARM);
      prescaler_en_r <= (mode_nxt != `OMC_M_SLOW_RUN_WITH_FAST_OSC) &
                        (mode_nxt != `OMC_M_SLOW_RUN_NO_FAST_OSC) &
                        (mode_nxt != `OMC_M_SLP1) &
                        (mode_nxt != `OMC_M_STOP);
      fast_osc_on_r <= (mode_nxt != `OMC_M_STOP) &
                       (mode_nxt != `OMC_M_SLP1) &
                       (mode_nxt != `OMC_M_SLP0) &
                       ((mode_nxt == `OMC_M_WARM) | fast_en |
                        (mode_nxt == `OMC_M_SRUN));
      low_osc_on_r  <= (mode_nxt != `OMC_M_STOP) & low_en;
      low_osc_pins_port_r <= ~low_en;
      // Deep-halt exit raises the time-base latch if armed
      time_base_interrupt_r <= tbt_armed_r & tb_fall &
                               ((mode_r == `OMC_M_SDEEP) |
                                (mode_r == `OMC_M_SLP0));
      warmup_done_interrupt_r <= wu_done & sw_warm_r;
      service_irq_r <= int_ctl_r[`OMC_IC_MASTER] &
                       (((mode_r == `OMC_M_SHALT ||
                          mode_r == `OMC_M_DHALT ||
                          mode_r == `OMC_M_SLP1) & irq_wake) |
                        (tbt_armed_r & tb_fall &
                         int_ctl_r[`OMC_IC_TBT_EN] &
                         (mode_r == `OMC_M_SDEEP ||
                          mode_r == `OMC_M_SLP0)));
    end
  end
  // ----------------------------------------------------------------
  // APB register writes
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      system_control_one_r   <= 8'h00;
      system_control_two_r   <= `OMC_SYSCTL2_RST;
      int_ctl_r              <= 3'h0;
      warmup_compare_value_r <= `OMC_WARMUP_RST;
    end
    else
    begin
      // Request bits self-clear once the mode is entered
      if (mode_r == `OMC_M_STOP)
        system_control_one_r[`OMC_C1_STOP] <= 1'b0;
      if (mode_r == `OMC_M_SHALT || mode_r == `OMC_M_DHALT ||
          mode_r == `OMC_M_SLP1)
        system_control_two_r[`OMC_C2_HALT] <= 1'b0;
      if (mode_r == `OMC_M_SDEEP || mode_r == `OMC_M_SLP0)
        system_control_two_r[`OMC_C2_TIMING_GEN_HALT_BIT] <= 1'b0;
      if (psel & penable & pwrite)
      begin
        case (paddr)
          `OMC_SYSCTL1_ADDR: system_control_one_r <= pwdata[7:0];
          `OMC_SYSCTL2_ADDR: system_control_two_r <= pwdata[7:0];
          `OMC_INTCTL_ADDR:  int_ctl_r <= pwdata[2:0];
          `OMC_WARMUP_ADDR:  warmup_compare_value_r <= pwdata[7:0];
          default:           ;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // APB read data
  // ----------------------------------------------------------------
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= 32'h00000000;
    else if (psel & ~penable & ~pwrite)
    begin
      case (paddr)
        `OMC_SYSCTL1_ADDR: prdata <= {24'h000000, system_control_one_r};
        `OMC_SYSCTL2_ADDR: prdata <= {24'h000000, system_control_two_r};
        `OMC_INTCTL_ADDR:  prdata <= {29'h00000000, int_ctl_r};
        `OMC_WARMUP_ADDR:  prdata <= {24'h000000, warmup_compare_value_r};
        `OMC_STATUS_ADDR:  prdata <= {27'h0000000, wu_busy, mode_r};
        `OMC_EVENT_ADDR:   prdata <= {30'h00000000,
                                      warmup_done_interrupt_r,
                                      time_base_interrupt_r};
        default:           prdata <= 32'h00000000;
      endcase
    end
  end
endmodule

/* File: logic/omc_defines.vh */
/*
  Register offsets, field positions, reset values and timing counts for the
  operating mode controller. Assumes inclusion by bare name.
*/
`ifndef OMC_DEFINES_VH
`define OMC_DEFINES_VH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define OMC_SYSCTL1_ADDR   12'h000
`define OMC_SYSCTL2_ADDR   12'h004
`define OMC_INTCTL_ADDR    12'h008
`define OMC_WARMUP_ADDR    12'h00C
`define OMC_STATUS_ADDR    12'h010
`define OMC_EVENT_ADDR     12'h014

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define OMC_C1_STOP        7
`define OMC_C2_XEN         7
`define OMC_C2_XTEN        6
`define OMC_C2_SYSTEM_CLOCK_SELECT_BIT       5
`define OMC_C2_TIMING_GEN_HALT_BIT      4
`define OMC_C2_HALT        3
`define OMC_IC_MASTER      0
`define OMC_IC_TBT_EN      1
`define OMC_IC_TIME_BASE_ENABLE_BIT_CTL   2
`define OMC_EV_TBT         0
`define OMC_EV_WUC         1

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define OMC_SYSCTL2_RST    8'h80
`define OMC_WARMUP_RST     8'h66
`define OMC_WUC_STAGES     14
`define OMC_CLK_PERIOD_NS  50

// ----------------------------------------------------------------
// Mode encodings
// ----------------------------------------------------------------
`define OMC_M_SRUN         4'h0
`define OMC_M_SHALT        4'h1
`define OMC_M_SDEEP        4'h2
`define OMC_M_DFAST        4'h3
`define OMC_M_DHALT        4'h4
`define OMC_M_SLOW_RUN_WITH_FAST_OSC        4'h5
`define OMC_M_SLOW_RUN_NO_FAST_OSC        4'h6
`define OMC_M_SLP1         4'h7
`define OMC_M_SLP0         4'h8
`define OMC_M_STOP         4'h9
`define OMC_M_WARM         4'hA

`endif

/* File: logic/omc_warmup.v */
/*
  Fourteen-stage warm-up counter; done when its upper eight bits match the
  compare value. Assumes start and clear are single-cycle pulses on pclk.
*/
`timescale 1ns/10ps
`include "omc_defines.vh"

module omc_warmup #(
  parameter STAGES = `OMC_WUC_STAGES
) (
  input  wire         pclk,
  input  wire         presetn,
  input  wire         start,
  input  wire         clear,
  input  wire [7:0]   cmp,
  output reg          busy_r,
  output reg          done_r
);

  reg  [STAGES-1:0]   cnt_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_r  <= {STAGES{1'b0}};
      busy_r <= 1'b0;
      done_r <= 1'b0;
    end
    else
    begin
      done_r <= 1'b0;
      if (clear)
      begin
        cnt_r  <= {STAGES{1'b0}};
        busy_r <= 1'b0;
      end
      else if (start)
      begin
        cnt_r  <= {STAGES{1'b0}};
        busy_r <= 1'b1;
      end
      else if (busy_r)
      begin
        if (cnt_r[STAGES-1:STAGES-8] == cmp)
        begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          cnt_r  <= {STAGES{1'b0}};
        end
        else
          cnt_r <= cnt_r + {{(STAGES-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule

/* File: verification/omc_top_asserts.sv */
/*
  Port-level checker for omc_top.
  Assumes a bind onto omc_top; all watched signals are its ports.
*/
`timescale 1ns/10ps
`include "omc_defines.vh"

module omc_chk (
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [7:0]  irq_latch,
  input wire [7:0]  interrupt_enable_register,
  input wire        cpu_clk_en_r,
  input wire        wdt_clk_en_r,
  input wire        periph_clk_en_r,
  input wire        tbt_clk_en_r,
  input wire        prescaler_en_r,
  input wire        fast_osc_on_r,
  input wire        low_osc_on_r,
  input wire        low_osc_pins_port_r,
  input wire        main_clk_sel_low_r,
  input wire        time_base_interrupt_r
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire wr_any = psel & penable & pwrite;
  wire wr2    = wr_any & (paddr == `OMC_SYSCTL2_ADDR);
  wire wr1    = wr_any & (paddr == `OMC_SYSCTL1_ADDR);
  wire srun   = cpu_clk_en_r & low_osc_pins_port_r;
  wire wake   = |(irq_latch & interrupt_enable_register);

  a_reset_run: assert property ($rose(presetn) |-> cpu_clk_en_r &&
    low_osc_pins_port_r && !low_osc_on_r && !main_clk_sel_low_r)
    else $error("run mode not entered after reset");
  a_halt_entry: assert property (wr2 && srun && pwdata[7:3] == 5'h11
    |-> ##2 !cpu_clk_en_r && !wdt_clk_en_r && periph_clk_en_r)
    else $error("cpu halt entry wrong");
  a_deep_entry: assert property (wr2 && srun && pwdata[7:3] == 5'h12
    |-> ##2 !cpu_clk_en_r && !periph_clk_en_r && tbt_clk_en_r)
    else $error("deep halt entry wrong");
  a_stop_entry: assert property (wr1 && pwdata[7] && cpu_clk_en_r
    |-> ##[1:2] !fast_osc_on_r && !low_osc_on_r && !cpu_clk_en_r)
    else $error("full stop entry wrong");
  a_cpu_wdt: assert property (cpu_clk_en_r == wdt_clk_en_r)
    else $error("cpu and watchdog gates differ");
  a_irq_wake: assert property (!cpu_clk_en_r && periph_clk_en_r
    && wake |-> ##[1:3] cpu_clk_en_r)
    else $error("enabled latch did not end halt");
  a_slow_prescale: assert property (main_clk_sel_low_r
    && periph_clk_en_r |-> !prescaler_en_r)
    else $error("prescaler runs in slow mode");
  a_slow_run_no_fast_osc_clock: assert property (low_osc_on_r && !fast_osc_on_r
    |-> main_clk_sel_low_r)
    else $error("slow clock not selected");
  a_pins_single: assert property (low_osc_pins_port_r
    |-> !low_osc_on_r)
    else $error("pins are ports while low osc runs");
  a_tbi_pulse: assert property (time_base_interrupt_r
    |=> !time_base_interrupt_r)
    else $error("time base latch pulse too long");
endmodule

bind omc_top omc_chk u_chk (.*);

/* File: verification/omc_tbsrc.sv */
/*
  Time-base source model: a slow clock that can be stood still.
  Assumes pclk and presetn from the bench.
*/
`timescale 1ns/10ps

module omc_tbsrc (
  input  wire pclk,
  input  wire presetn,
  input  wire run,
  output reg  tb_source_clk
);
  // ----------------------------------------------------------------
  // Divider, frozen while run is low
  // ----------------------------------------------------------------
  reg [2:0] div_r;

  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_r         <= 3'h0;
      tb_source_clk <= 1'b1;
    end
    else if (run)
    begin
      div_r <= div_r + 3'h1;
      if (div_r == 3'h7)
        tb_source_clk <= ~tb_source_clk;
    end
  end
endmodule

/* File: verification/tb.sv */
/*
  Self-checking bench for omc_top over APB.
  Assumes omc_top, omc_tbsrc and the checker are compiled first.
*/
`timescale 1ns/10ps
`include "omc_defines.vh"
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  error_cnt++; $display("ERROR %s exp %0h got %0h", n, e, g); end end

module tb;
  logic        pclk = 0;
  logic        presetn = 0;
  logic        psel = 0;
  logic        penable = 0;
  logic        pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [7:0]  irq_latch = 8'h00;
  logic [7:0]  interrupt_enable_register = 8'h01;
  logic        stop_release = 0;
  logic        periph_sel_low = 1;
  logic        run = 1;
  logic [31:0] q;
  wire  [31:0] prdata;
  wire         pready, pslverr, tb_source_clk, service_irq_r;
  wire         main_clk_sel_low_r, cpu_clk_en_r, wdt_clk_en_r;
  wire         periph_clk_en_r, periph_clk_low_r, tbt_clk_en_r;
  wire         prescaler_en_r, fast_osc_on_r, low_osc_on_r;
  wire         low_osc_pins_port_r, time_base_interrupt_r;
  wire         warmup_done_interrupt_r;
  wire  [3:0]  flg = {main_clk_sel_low_r, fast_osc_on_r,
                      low_osc_pins_port_r, prescaler_en_r};
  wire  [3:0]  offs = {main_clk_sel_low_r, periph_clk_low_r,
                       low_osc_on_r, low_osc_pins_port_r};
  wire  [5:0]  ens = {cpu_clk_en_r, wdt_clk_en_r, periph_clk_en_r,
                      tbt_clk_en_r, prescaler_en_r, fast_osc_on_r};
  int          error_cnt = 0;
  int          num_checks = 0;
  int          cyc = 0;
  int          tbi = 0;
  int          svc = 0;
  int          wdi = 0;
  int          n;
  // Row: SYSCTL2 data, mode, {slow sel, fast osc, pins port, prescaler}
  logic [15:0] rows [5] = '{16'hC035, 16'hE05C, 16'hC035, 16'hE05C,
                            16'h6068};

  omc_top dut (.*);
  omc_tbsrc u_src (.*);

  // ----------------------------------------------------------------
  // Clock, monitors, bus tasks
  // ----------------------------------------------------------------
  initial forever #25 pclk = ~pclk;

  always @(posedge pclk)
  begin
    tbi += (time_base_interrupt_r === 1'b1);
    svc += (service_irq_r === 1'b1);
    wdi += (warmup_done_interrupt_r === 1'b1);
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      finish_test;
    end
  end

  task finish_test;
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task wt(input int k);
    repeat (k) @(posedge pclk);
    #1;
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1;
    penable <= 0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    psel    <= 0;
    penable <= 0;
  endtask

  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1, a, {24'h0, d});
  endtask

  task rdchk(input logic [11:0] a, input logic [31:0] e);
    apb(0, a, 32'h0);
    `CHK("read", e, q)
  endtask

  task mode(input logic [3:0] m);
    rdchk(`OMC_STATUS_ADDR, {28'h0, m});
  endtask

  task halt(input logic [7:0] c2);
    wr(`OMC_SYSCTL2_ADDR, c2);
    wt(3);
    `CHK("halt", 3'h1, {cpu_clk_en_r, wdt_clk_en_r, periph_clk_en_r})
    @(posedge pclk);
    interrupt_enable_register <= 8'h01;
    irq_latch <= 8'h02;
    wt(4);
    `CHK("masked", 1'b0, cpu_clk_en_r)
    @(posedge pclk);
    interrupt_enable_register <= 8'h03;
    wt(3);
    `CHK("wake", 1'b1, cpu_clk_en_r)
    @(posedge pclk);
    irq_latch <= 8'h00;
  endtask

  task deep(input logic [7:0] c2, input logic [7:0] ic, input int et,
            input int es);
    int t0;
    int s0;
    wr(`OMC_INTCTL_ADDR, ic);
    t0 = tbi;
    s0 = svc;
    @(posedge pclk);
    run <= 0;
    wr(`OMC_SYSCTL2_ADDR, c2);
    wt(3);
    `CHK("deep", 3'h1, {cpu_clk_en_r, periph_clk_en_r, tbt_clk_en_r})
    wt(20);
    `CHK("asleep", 1'b0, cpu_clk_en_r)
    @(posedge pclk);
    run <= 1;
    while (cpu_clk_en_r !== 1'b1) @(posedge pclk);
    wt(4);
    `CHK("tb_irq", et, tbi - t0)
    `CHK("service", es, svc - s0)
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1;
    wr(`OMC_WARMUP_ADDR, 8'h00);
    for (int i = 0; i < 5; i++)
    begin
      wr(`OMC_SYSCTL2_ADDR, rows[i][15:8]);
      wt(3);
      mode(rows[i][7:4]);
      `CHK("clocks", rows[i][3:0], flg)
      `CHK("periph_low", 1'b1, periph_clk_low_r)
    end
    halt(8'h68);
    mode(4'h6);
    deep(8'h70, 8'h00, 0, 0);
    mode(4'h6);
    n = wdi;
    wr(`OMC_WARMUP_ADDR, 8'h02);
    wr(`OMC_SYSCTL2_ADDR, 8'hE0);
    wt(20);
    rdchk(`OMC_STATUS_ADDR, 32'h16);
    wt(200);
    `CHK("warm_irq", 1, wdi - n)
    mode(4'h5);
    wr(`OMC_SYSCTL2_ADDR, 8'hC0);
    wt(3);
    @(posedge pclk);
    periph_sel_low <= 0;
    wt(2);
    `CHK("periph_gear", 1'b0, periph_clk_low_r)
    @(posedge pclk);
    periph_sel_low <= 1;
    halt(8'hC8);
    mode(4'h3);
    @(posedge pclk);
    presetn <= 0;
    wt(2);
    `CHK("rst_en", 6'h3F, ens)
    @(posedge pclk);
    presetn <= 1;
    wt(1);
    mode(4'h0);
    rdchk(`OMC_SYSCTL2_ADDR, 32'h80);
    rdchk(`OMC_WARMUP_ADDR, 32'h66);
    `CHK("single", 4'h1, offs)
    wr(`OMC_INTCTL_ADDR, 8'h07);
    wr(12'h03C, 8'hFF);
    rdchk(12'h03C, 32'h0);
    rdchk(`OMC_INTCTL_ADDR, 32'h07);
    halt(8'h88);
    mode(4'h0);
    deep(8'h90, 8'h07, 1, 1);
    deep(8'h90, 8'h04, 1, 0);
    deep(8'h90, 8'h01, 0, 0);
    mode(4'h0);
    wr(`OMC_WARMUP_ADDR, 8'h02);
    wr(`OMC_SYSCTL1_ADDR, 8'h80);
    wt(3);
    `CHK("stop", 3'h0, {fast_osc_on_r, low_osc_on_r, cpu_clk_en_r})
    @(posedge pclk);
    stop_release <= 1;
    n = 0;
    while (cpu_clk_en_r !== 1'b1)
    begin
      @(posedge pclk);
      n++;
    end
    `CHK("warm_len", 1, n >= 128 && n <= 145)
    stop_release <= 0;
    mode(4'h0);
    finish_test;
  end
endmodule
